// ===== src/dcch_top.sv
module dcch_top #(
   parameter int HOST_WAIT = dcch_pkg::HOST_WAIT_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Drive and link events, same clock
   input wire logic drive_enabled,
   input wire logic host_seen,
   input wire logic cmd_push,
   input wire logic cmd_pop,
   // Command buffer answer
   output logic cmd_accept,
   // Link rate
   output logic [2:0] baud_code,
   output logic session_drop,
   output logic power_up_wait,
   // Brake outputs per I/O point
   output logic [3:0] brake_level,
   output logic [3:0] brake_own,
   // Current settings
   output logic [9:0] run_current,
   output logic [9:0] idle_current,
   output logic [9:0] accel_current,
   // Interrupt
   output logic irq
);
   dcch_pkg::dcch_state_t s_reg;
   dcch_pkg::dcch_state_t s_next;
   dcch_pkg::dcch_bus_t bus;

   logic timer_wait;
   logic timer_expired;
   logic [3:0] own_w;
   logic [3:0] lvl_w;
   logic [2:0] brake_pt_eff;

   assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   // Standard drives write point 0, meaning the single output
   assign brake_pt_eff = (s_reg.brake_point == 3'h0) ? 3'h1 : s_reg.brake_point;

   dcch_host_timer #(
      .WAIT_CYCLES(HOST_WAIT)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .host_seen(host_seen),
      .waiting(timer_wait),
      .expired(timer_expired)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_point
         assign own_w[gi] = (s_reg.brake_code == dcch_pkg::BRAKE_CLOSED_EN
                             || s_reg.brake_code == dcch_pkg::BRAKE_OPEN_EN)
                            && brake_pt_eff == 3'(gi + 1);
         assign lvl_w[gi] = !own_w[gi] ? 1'b1 :
                            (s_reg.brake_code == dcch_pkg::BRAKE_CLOSED_EN)
                            ? !drive_enabled : drive_enabled;
      end
   endgenerate

   always_comb begin
      logic [3:0] ev;
      logic [1:0] wcode;
      logic [2:0] wpoint;
      logic [2:0] wbaud;
      logic [9:0] wcur;
      logic [1:0] wfunc;
      logic [2:0] wfpoint;
      logic wpt_ok;
      logic push_ok;
      ev = 4'h0;
      wcode = bus.wdata[dcch_pkg::BRAKE_CODE_LSB +: 2];
      wpoint = bus.wdata[dcch_pkg::BRAKE_POINT_LSB +: 3];
      wbaud = bus.wdata[2:0];
      wcur = bus.wdata[9:0];
      wfunc = bus.wdata[dcch_pkg::FUNC_LSB +: 2];
      wfpoint = bus.wdata[dcch_pkg::FUNC_POINT_LSB +: 3];
      wpt_ok = 1'b0;
      push_ok = 1'b0;
      s_next = s_reg;
      s_next.session_drop = 1'b0;
      s_next.cmd_accept = 1'b0;
      s_next.rdata = 16'h0000;

      push_ok = cmd_push && s_reg.free_slots != 6'h00;
      if (cmd_push && !push_ok) begin
         ev[dcch_pkg::ST_OVERFLOW] = 1'b1;
      end
      s_next.cmd_accept = push_ok;
      if (push_ok && !(cmd_pop && s_reg.free_slots != dcch_pkg::FREE_SLOTS_RST)) begin
         s_next.free_slots = s_reg.free_slots - 6'h01;
      end else if (!push_ok && cmd_pop && s_reg.free_slots != dcch_pkg::FREE_SLOTS_RST) begin
         s_next.free_slots = s_reg.free_slots + 6'h01;
      end

      if (timer_expired && s_reg.pu_mode == dcch_pkg::PU_MODE_CMD) begin
         s_next.baud_act = s_reg.baud_nv;
         ev[dcch_pkg::ST_BAUD_SWITCH] = 1'b1;
      end

      if (bus.wr) begin
         unique case (bus.addr)
            dcch_pkg::ADDR_BRAKE: begin
               if (wpoint == 3'h0) begin
                  wpt_ok = s_reg.io_dir[0];
               end else if (wpoint <= 3'h4) begin
                  wpt_ok = s_reg.io_dir[wpoint[1:0] - 2'h1];
               end
               if (wcode == 2'h0 || (wcode != dcch_pkg::BRAKE_UNUSED && !wpt_ok)) begin
                  ev[dcch_pkg::ST_REJECT] = 1'b1;
               end else begin
                  s_next.brake_code = wcode;
                  s_next.brake_point = wpoint;
               end
            end
            dcch_pkg::ADDR_IO_DIR: begin
               s_next.io_dir = bus.wdata[3:0];
            end
            dcch_pkg::ADDR_FUNC_ASSIGN: begin
               if ((wfunc == dcch_pkg::FUNC_ALARM || wfunc == dcch_pkg::FUNC_MOTION)
                   && ((wfpoint == 3'h0 ? 3'h1 : wfpoint) == brake_pt_eff)) begin
                  s_next.brake_code = dcch_pkg::BRAKE_UNUSED;
               end
            end
            dcch_pkg::ADDR_BAUD: begin
               if (wbaud >= dcch_pkg::BAUD_9600 && wbaud <= dcch_pkg::BAUD_115200) begin
                  s_next.baud_nv = wbaud;
                  s_next.baud_act = wbaud;
                  s_next.session_drop = 1'b1;
                  ev[dcch_pkg::ST_SESSION_DROP] = 1'b1;
               end else begin
                  ev[dcch_pkg::ST_REJECT] = 1'b1;
               end
            end
            dcch_pkg::ADDR_RUN_CUR: begin
               if (wcur > s_reg.max_cur || bus.wdata[15:10] != 6'h00) begin
                  ev[dcch_pkg::ST_REJECT] = 1'b1;
               end else begin
                  s_next.run_cur = wcur;
                  s_next.idle_cur = {1'b0, wcur[9:1]};
               end
            end
            dcch_pkg::ADDR_ACCEL_CUR: begin
               if (wcur < s_reg.run_cur || wcur > dcch_pkg::CUR_FULL_SCALE
                   || bus.wdata[15:10] != 6'h00) begin
                  ev[dcch_pkg::ST_REJECT] = 1'b1;
               end else begin
                  s_next.accel_cur = wcur;
               end
            end
            dcch_pkg::ADDR_IDLE_CUR: begin
               if (wcur > s_reg.run_cur || bus.wdata[15:10] != 6'h00) begin
                  ev[dcch_pkg::ST_REJECT] = 1'b1;
               end else begin
                  s_next.idle_cur = wcur;
               end
            end
            dcch_pkg::ADDR_MAX_CUR: begin
               s_next.max_cur = (wcur > dcch_pkg::CUR_FULL_SCALE || bus.wdata[15:10] != 6'h00)
                                ? dcch_pkg::CUR_FULL_SCALE : wcur;
            end
            dcch_pkg::ADDR_CMD_MODE: begin
               s_next.cmd_mode = bus.wdata[4:0];
            end
            dcch_pkg::ADDR_PU_MODE: begin
               s_next.pu_mode = bus.wdata[1:0];
            end
            dcch_pkg::ADDR_MASK: begin
               s_next.mask = bus.wdata[3:0];
            end
            default: begin
            end
         endcase
      end

      if (bus.rd) begin
         unique case (bus.addr)
            dcch_pkg::ADDR_BRAKE: s_next.rdata = {11'h000, s_reg.brake_point, s_reg.brake_code};
            dcch_pkg::ADDR_IO_DIR: s_next.rdata = {12'h000, s_reg.io_dir};
            dcch_pkg::ADDR_BAUD: s_next.rdata = {13'h0000, s_reg.baud_nv};
            dcch_pkg::ADDR_BAUD_ACTIVE: s_next.rdata = {13'h0000, s_reg.baud_act};
            dcch_pkg::ADDR_BUF_SPACE: s_next.rdata = {10'h000, s_reg.free_slots};
            dcch_pkg::ADDR_RUN_CUR: s_next.rdata = {6'h00, s_reg.run_cur};
            dcch_pkg::ADDR_ACCEL_CUR: s_next.rdata = {6'h00, s_reg.accel_cur};
            dcch_pkg::ADDR_IDLE_CUR: s_next.rdata = {6'h00, s_reg.idle_cur};
            dcch_pkg::ADDR_MAX_CUR: s_next.rdata = {6'h00, s_reg.max_cur};
            dcch_pkg::ADDR_CMD_MODE: s_next.rdata = {11'h000, s_reg.cmd_mode};
            dcch_pkg::ADDR_PU_MODE: s_next.rdata = {14'h0000, s_reg.pu_mode};
            dcch_pkg::ADDR_STATUS: s_next.rdata = {12'h000, s_reg.status};
            dcch_pkg::ADDR_MASK: s_next.rdata = {12'h000, s_reg.mask};
            default: s_next.rdata = 16'h0000;
         endcase
      end

      // New events win over the clear by read
      if (bus.rd && bus.addr == dcch_pkg::ADDR_STATUS) begin
         s_next.status = ev;
      end else begin
         s_next.status = s_reg.status | ev;
      end
      s_next.irq = |(s_next.status & s_next.mask);

      s_next.accel_eff = (s_next.cmd_mode == dcch_pkg::STEP_DIR_MODE)
                         ? s_next.run_cur : s_next.accel_cur;
      s_next.brake_own = own_w;
      s_next.brake_level = lvl_w;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '{
            brake_code: dcch_pkg::BRAKE_UNUSED,
            brake_point: 3'h0,
            io_dir: 4'h0,
            baud_nv: dcch_pkg::BAUD_NV_RST,
            baud_act: dcch_pkg::BAUD_9600,
            run_cur: dcch_pkg::RUN_CUR_RST,
            accel_cur: dcch_pkg::RUN_CUR_RST,
            idle_cur: {1'b0, dcch_pkg::RUN_CUR_RST[9:1]},
            max_cur: dcch_pkg::MAX_CUR_RST,
            cmd_mode: dcch_pkg::CMD_MODE_RST,
            pu_mode: dcch_pkg::PU_MODE_RST,
            free_slots: dcch_pkg::FREE_SLOTS_RST,
            status: 4'h0,
            mask: 4'h0,
            rdata: 16'h0000,
            irq: 1'b0,
            brake_level: 4'hf,
            brake_own: 4'h0,
            accel_eff: dcch_pkg::RUN_CUR_RST,
            session_drop: 1'b0,
            cmd_accept: 1'b0
         };
         power_up_wait <= 1'b1;
      end else if (ce) begin
         s_reg <= s_next;
         power_up_wait <= timer_wait;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign cmd_accept = s_reg.cmd_accept;
   assign baud_code = s_reg.baud_act;
   assign session_drop = s_reg.session_drop;
   assign brake_level = s_reg.brake_level;
   assign brake_own = s_reg.brake_own;
   assign run_current = s_reg.run_cur;
   assign idle_current = s_reg.idle_cur;
   assign accel_current = s_reg.accel_eff;
   assign irq = s_reg.irq;
endmodule

// ===== src/dcch_pkg.sv
// How it works
// - Brake code 1: selected output closed (low) while enabled, open while disabled.
// - Brake code 2: selected output open (high) while enabled, closed while disabled.
// - Brake code 3: selected output is released, not driven as brake.
// - Brake point 1 to 4 must already be configured as an output.
// - Brake code 1/2 takes the output; later alarm/motion assign forces code 3.
// - After power up the link runs at 9600 baud whatever is stored.
// - No host within 1 s and command mode: switch to stored baud.
// - Baud codes 1..5 map to 9600..115200; readable, writable, retained; rstn reloads stored code 1 here.
// - Baud write acts at once and drops the session; host reconnects.
// - Buffer-space query returns free slots: 63 empty, 0 full.
// - With no free slot a further command is refused and flags overflow.
// - Accel current below running current is refused.
// - Accel current has no effect in step-and-direction mode 7.
// - Currents held in 0.01 A steps; running current 0 to 5.00 A.
// - Running current is limited to the configured maximum current.
// - Writing running current sets idle current to half of it.
package dcch_pkg;

   // Register indices on the plain port
   localparam logic [3:0] ADDR_BRAKE = 4'h0;
   localparam logic [3:0] ADDR_IO_DIR = 4'h1;
   localparam logic [3:0] ADDR_FUNC_ASSIGN = 4'h2;
   localparam logic [3:0] ADDR_BAUD = 4'h3;
   localparam logic [3:0] ADDR_BAUD_ACTIVE = 4'h4;
   localparam logic [3:0] ADDR_BUF_SPACE = 4'h5;
   localparam logic [3:0] ADDR_RUN_CUR = 4'h6;
   localparam logic [3:0] ADDR_ACCEL_CUR = 4'h7;
   localparam logic [3:0] ADDR_IDLE_CUR = 4'h8;
   localparam logic [3:0] ADDR_MAX_CUR = 4'h9;
   localparam logic [3:0] ADDR_CMD_MODE = 4'ha;
   localparam logic [3:0] ADDR_PU_MODE = 4'hb;
   localparam logic [3:0] ADDR_STATUS = 4'hc;
   localparam logic [3:0] ADDR_MASK = 4'hd;

   // Field positions
   localparam int BRAKE_CODE_LSB = 0;
   localparam int BRAKE_POINT_LSB = 2;
   localparam int FUNC_LSB = 0;
   localparam int FUNC_POINT_LSB = 2;

   // Codes
   localparam logic [1:0] BRAKE_CLOSED_EN = 2'h1;
   localparam logic [1:0] BRAKE_OPEN_EN = 2'h2;
   localparam logic [1:0] BRAKE_UNUSED = 2'h3;
   localparam logic [1:0] FUNC_ALARM = 2'h1;
   localparam logic [1:0] FUNC_MOTION = 2'h2;
   localparam logic [2:0] BAUD_9600 = 3'h1;
   localparam logic [2:0] BAUD_115200 = 3'h5;
   localparam logic [4:0] STEP_DIR_MODE = 5'h07;
   localparam logic [1:0] PU_MODE_CMD = 2'h2;

   // Reset values and current full scale
   localparam logic [2:0] BAUD_NV_RST = 3'h1;
   localparam logic [5:0] FREE_SLOTS_RST = 6'h3f;
   localparam logic [9:0] CUR_FULL_SCALE = 10'h1f4;
   localparam logic [9:0] RUN_CUR_RST = 10'h064;
   localparam logic [9:0] MAX_CUR_RST = 10'h1f4;
   localparam logic [4:0] CMD_MODE_RST = 5'h00;
   localparam logic [1:0] PU_MODE_RST = 2'h2;

   // Status bits
   localparam int ST_OVERFLOW = 0;
   localparam int ST_REJECT = 1;
   localparam int ST_BAUD_SWITCH = 2;
   localparam int ST_SESSION_DROP = 3;

   // Timing
   localparam int CLK_MHZ = 250;
   localparam int HOST_WAIT_MS = 1000;
   localparam int HOST_WAIT_CYCLES = HOST_WAIT_MS * 1000 * CLK_MHZ;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } dcch_bus_t;

   typedef struct packed {
      logic [1:0] brake_code;
      logic [2:0] brake_point;
      logic [3:0] io_dir;
      logic [2:0] baud_nv;
      logic [2:0] baud_act;
      logic [9:0] run_cur;
      logic [9:0] accel_cur;
      logic [9:0] idle_cur;
      logic [9:0] max_cur;
      logic [4:0] cmd_mode;
      logic [1:0] pu_mode;
      logic [5:0] free_slots;
      logic [3:0] status;
      logic [3:0] mask;
      logic [15:0] rdata;
      logic irq;
      logic [3:0] brake_level;
      logic [3:0] brake_own;
      logic [9:0] accel_eff;
      logic session_drop;
      logic cmd_accept;
   } dcch_state_t;

   typedef struct packed {
      logic [27:0] count;
      logic waiting;
      logic expired;
   } dcch_timer_t;

endpackage

// ===== src/dcch_host_timer.sv
// Power-up host wait: pulses once if no host is seen in time
module dcch_host_timer #(
   parameter int WAIT_CYCLES = dcch_pkg::HOST_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Host activity
   input wire logic host_seen,
   // Result
   output logic waiting,
   output logic expired
);
   localparam logic [27:0] LAST = 28'(WAIT_CYCLES - 1);

   dcch_pkg::dcch_timer_t st_reg;
   dcch_pkg::dcch_timer_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.expired = 1'b0;
      if (st_reg.waiting) begin
         if (host_seen) begin
            st_next.waiting = 1'b0;
         end else if (st_reg.count == LAST) begin
            st_next.waiting = 1'b0;
            st_next.expired = 1'b1;
         end else begin
            st_next.count = st_reg.count + 28'h0000001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '{count: 28'h0000000, waiting: 1'b1, expired: 1'b0};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign waiting = st_reg.waiting;
   assign expired = st_reg.expired;
endmodule

// ===== sim/dcch_monitor.sv
module dcch_monitor #(
   parameter int HOST_WAIT = 20
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Drive and link events
   input wire logic drive_enabled,
   input wire logic host_seen,
   input wire logic cmd_push,
   input wire logic cmd_pop,
   input wire logic cmd_accept,
   // Link rate
   input wire logic [2:0] baud_code,
   input wire logic session_drop,
   input wire logic power_up_wait,
   // Brake and currents
   input wire logic [3:0] brake_level,
   input wire logic [3:0] brake_own,
   input wire logic [9:0] run_current,
   input wire logic [9:0] idle_current,
   input wire logic [9:0] accel_current,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] wait_cnt_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Counts the power-up wait, stops when it ends
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) wait_cnt_reg <= '0;
      else if (power_up_wait) wait_cnt_reg <= wait_cnt_reg + 32'h1;
   end
   a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
      else $error("read data outside answer cycle");
   a_released_high: assert property (&(brake_level | brake_own))
      else $error("released point driven low");
   a_brake_toggle: assert property (ce && $changed(drive_enabled)
      && !reg_wr && !$past(reg_wr)
      |=> ((brake_level ^ $past(brake_level)) & brake_own) == brake_own)
      else $error("brake did not follow enable");
   a_baud_legal: assert property (baud_code inside {[3'h1:3'h5]})
      else $error("rate code out of range");
   a_early_rate: assert property (power_up_wait |-> baud_code == dcch_pkg::BAUD_9600)
      else $error("rate not base during wait");
   a_baud_session: assert property (ce && reg_wr && reg_addr == dcch_pkg::ADDR_BAUD
      && reg_wdata[2:0] inside {[3'h1:3'h5]}
      |=> session_drop && baud_code == $past(reg_wdata[2:0]) ##1 !session_drop)
      else $error("rate write without session drop");
   a_accept_cause: assert property (cmd_accept |-> $past(cmd_push) && $past(ce))
      else $error("accept without push");
   a_idle_half: assert property ($changed(run_current) |-> idle_current == run_current >> 1)
      else $error("idle not half of run");
   a_run_ceiling: assert property (run_current <= dcch_pkg::CUR_FULL_SCALE)
      else $error("run current above full scale");
   a_accel_floor: assert property (ce && reg_wr && reg_addr == dcch_pkg::ADDR_ACCEL_CUR
      && reg_wdata[9:0] < run_current |=> $stable(accel_current))
      else $error("low accel current taken");
   a_wait_bound: assert property (wait_cnt_reg <= HOST_WAIT + 3)
      else $error("power-up wait too long");
endmodule

// ===== sim/dcch_host_model.sv
module dcch_host_model (
   // Clock
   input wire logic clk,
   // Link events toward the drive
   output logic host_seen,
   output logic cmd_push,
   output logic cmd_pop
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_seen = 1'b0;
      cmd_push = 1'b0;
      cmd_pop = 1'b0;
   end
   task automatic send(input int n, input logic pop);
      repeat (n) begin
         @(posedge clk);
         if (pop) cmd_pop <= 1'b1;
         else cmd_push <= 1'b1;
         @(posedge clk);
         cmd_push <= 1'b0;
         cmd_pop <= 1'b0;
      end
   endtask
   // Host answer during power-up wait
   task automatic seen();
      @(posedge clk);
      host_seen <= 1'b1;
      @(posedge clk);
      host_seen <= 1'b0;
   endtask
endmodule

// ===== sim/dcch_top_tb.sv
module dcch_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HW = 20;
   logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, drive_enabled = 1'b0;
   logic ce = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0;
   logic [15:0] reg_rdata;
   logic cmd_accept, session_drop, power_up_wait, irq, host_seen, cmd_push, cmd_pop;
   logic [2:0] baud_code;
   logic [3:0] brake_level, brake_own;
   logic [9:0] run_current, idle_current, accel_current, v;
   logic [15:0] exp_rd[$];
   logic exp_acc[$];
   logic rd_d = 1'b0, push_d = 1'b0;
   int fail_count = 0, cmp_count = 0;
   logic [31:0] seed = 32'h9478a19d;
   logic [3:0] ra[12] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
   logic [15:0] rv[12] = '{16'h3, 16'h0, 16'h1, 16'h3f, 16'h64, 16'h64, 16'h32, 16'h1f4,
      16'h0, 16'h2, 16'h0, 16'h0};
   always #2 clk = ~clk;
   dcch_top #(.HOST_WAIT(HW)) dut_u (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .drive_enabled(drive_enabled), .host_seen(host_seen), .cmd_push(cmd_push),
      .cmd_pop(cmd_pop), .cmd_accept(cmd_accept), .baud_code(baud_code),
      .session_drop(session_drop), .power_up_wait(power_up_wait), .brake_level(brake_level),
      .brake_own(brake_own), .run_current(run_current), .idle_current(idle_current),
      .accel_current(accel_current), .irq(irq));
   dcch_host_model host_u (.clk(clk), .host_seen(host_seen), .cmd_push(cmd_push),
      .cmd_pop(cmd_pop));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_rd.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Outputs settle after the edge lands
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic results();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rd_d) chk(reg_rdata, exp_rd.pop_front());
      if (push_d) chk(16'(cmd_accept), 16'(exp_acc.pop_front()));
      rd_d <= reg_rd;
      push_d <= cmd_push;
   end
   initial begin
      #80000;
      fail_count++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(dcch_pkg::ADDR_BAUD_ACTIVE, 16'h1);
      foreach (ra[i]) rd(ra[i], rv[i]);
      for (int i = 0; i < 50 && power_up_wait !== 1'b0; i++) @(posedge clk);
      settle(0);
      chk(16'({power_up_wait, baud_code}), 16'h1);
      rd(dcch_pkg::ADDR_STATUS, 16'h4);
      rd(dcch_pkg::ADDR_STATUS, 16'h0);
      $display("reset and power-up test done");
      wr(dcch_pkg::ADDR_MASK, 16'h2);
      wr(dcch_pkg::ADDR_BRAKE, 16'h5);
      settle(2);
      chk(16'(irq), 16'h1);
      rd(dcch_pkg::ADDR_BRAKE, 16'h3);
      rd(dcch_pkg::ADDR_STATUS, 16'h2);
      settle(2);
      chk(16'(irq), 16'h0);
      wr(dcch_pkg::ADDR_MASK, 16'h0);
      wr(dcch_pkg::ADDR_BRAKE, 16'h5);
      settle(2);
      chk(16'(irq), 16'h0);
      rd(dcch_pkg::ADDR_STATUS, 16'h2);
      $display("refusal and interrupt test done");
      wr(dcch_pkg::ADDR_IO_DIR, 16'hf);
      for (int c = 1; c < 3; c++) begin
         for (int p = 1; p < 5; p++) begin
            wr(dcch_pkg::ADDR_BRAKE, 16'(p * 4 + c));
            for (int e = 0; e < 2; e++) begin
               @(posedge clk) drive_enabled <= e[0];
               settle(2);
               chk(16'(brake_own), 16'(1 << (p - 1)));
               chk(16'(brake_level[p - 1]), 16'((c == 1) ^ e[0]));
            end
            // Same encoding picks alarm for 1, motion for 2
            wr(dcch_pkg::ADDR_FUNC_ASSIGN, 16'(p * 4 + c));
            settle(2);
            chk({8'h0, brake_own, brake_level}, 16'h0f);
         end
      end
      $display("brake test done");
      for (int c = 1; c < 6; c++) begin
         wr(dcch_pkg::ADDR_BAUD, 16'(c));
         settle(0);
         chk(16'(baud_code), 16'(c));
         rd(dcch_pkg::ADDR_BAUD_ACTIVE, 16'(c));
      end
      wr(dcch_pkg::ADDR_BAUD, 16'h6);
      rd(dcch_pkg::ADDR_BAUD, 16'h5);
      rd(dcch_pkg::ADDR_STATUS, 16'ha);
      $display("rate test done");
      repeat (63) exp_acc.push_back(1'b1);
      host_u.send(63, 1'b0);
      rd(dcch_pkg::ADDR_BUF_SPACE, 16'h0);
      exp_acc.push_back(1'b0);
      host_u.send(1, 1'b0);
      rd(dcch_pkg::ADDR_STATUS, 16'h1);
      host_u.send(1, 1'b1);
      rd(dcch_pkg::ADDR_BUF_SPACE, 16'h1);
      $display("buffer test done");
      repeat (4) begin
         seed = lfsr(seed);
         v = 10'(seed % 501);
         wr(dcch_pkg::ADDR_ACCEL_CUR, 16'h1f4);
         wr(dcch_pkg::ADDR_RUN_CUR, 16'(v));
         rd(dcch_pkg::ADDR_RUN_CUR, 16'(v));
         rd(dcch_pkg::ADDR_IDLE_CUR, 16'(v >> 1));
         wr(dcch_pkg::ADDR_ACCEL_CUR, 16'(v - 10'h1));
         rd(dcch_pkg::ADDR_ACCEL_CUR, 16'h1f4);
         wr(dcch_pkg::ADDR_ACCEL_CUR, 16'(v));
         rd(dcch_pkg::ADDR_ACCEL_CUR, 16'(v));
      end
      wr(dcch_pkg::ADDR_RUN_CUR, 16'h1f5);
      rd(dcch_pkg::ADDR_RUN_CUR, 16'(v));
      wr(dcch_pkg::ADDR_ACCEL_CUR, 16'h1f4);
      wr(dcch_pkg::ADDR_MAX_CUR, 16'hc8);
      wr(dcch_pkg::ADDR_RUN_CUR, 16'hc9);
      rd(dcch_pkg::ADDR_RUN_CUR, 16'(v));
      wr(dcch_pkg::ADDR_RUN_CUR, 16'hc8);
      rd(dcch_pkg::ADDR_RUN_CUR, 16'hc8);
      wr(dcch_pkg::ADDR_CMD_MODE, 16'h7);
      settle(1);
      chk(16'(accel_current), 16'hc8);
      $display("current test done");
      // Two more resets: host answers in the first, command mode off in the second, so no rate switch
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) rstn <= 1'b0;
         repeat (3) @(posedge clk);
         rstn <= 1'b1;
         if (k == 0) host_u.seen();
         else wr(dcch_pkg::ADDR_PU_MODE, 16'h0);
         settle(HW + 4);
         chk(16'({power_up_wait, baud_code}), 16'h1);
         rd(dcch_pkg::ADDR_STATUS, 16'h0);
      end
      // A write while the enable is low must not land
      @(posedge clk) ce <= 1'b0;
      wr(dcch_pkg::ADDR_RUN_CUR, 16'h10);
      ce <= 1'b1;
      rd(dcch_pkg::ADDR_RUN_CUR, 16'h64);
      $display("reset and enable test done");
      settle(3);
      results();
   end
endmodule

bind dcch_top dcch_monitor #(.HOST_WAIT(HOST_WAIT)) mon_u (.clk(clk), .rstn(rstn), .ce(ce),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .drive_enabled(drive_enabled), .host_seen(host_seen),
   .cmd_push(cmd_push), .cmd_pop(cmd_pop), .cmd_accept(cmd_accept), .baud_code(baud_code),
   .session_drop(session_drop), .power_up_wait(power_up_wait), .brake_level(brake_level),
   .brake_own(brake_own), .run_current(run_current), .idle_current(idle_current),
   .accel_current(accel_current), .irq(irq));
